// ---- design/sac_pkg.sv ----
// constants for the converter conversion and readout timing block
package sac_pkg;
   // clock
   localparam int CLK_NS = 5;
   // result width (also the serial frame length) and timer counter width
   localparam int DATA_W = 16;
   localparam int CNT_W = 8;
   // busy timing
   localparam int BUSY_MAX_NS = 1250;
   localparam int BUSY_MAX_CYC = BUSY_MAX_NS / CLK_NS;
   localparam int DV_BUSY_NS = 45;
   localparam int DV_BUSY_CYC = (DV_BUSY_NS + CLK_NS - 1) / CLK_NS;
   localparam int EOC_BUSY_NS = 10;
   localparam int EOC_BUSY_CYC = (EOC_BUSY_NS + CLK_NS - 1) / CLK_NS;
   // tail covers buffer pop and parallel load (2) before the 45 ns window
   localparam int TAIL_CYC = (DV_BUSY_CYC + 2 > EOC_BUSY_CYC) ?
      DV_BUSY_CYC + 2 : EOC_BUSY_CYC;
   // margin of 4 cycles absorbs the pin synchroniser and busy register
   localparam int CONV_CYC = BUSY_MAX_CYC - TAIL_CYC - 4;
   localparam int LAG_NS = 25;
   localparam int LAG_CYC = (LAG_NS + CLK_NS - 1) / CLK_NS;
   // serial master timing, index is the divider code
   localparam int LEAD_NS = 17;
   localparam int LEAD_CYC = (LEAD_NS + CLK_NS - 1) / CLK_NS;
   localparam int SCLK_PER_NS [4] = '{30, 60, 120, 240};
   localparam int HALF_CYC [4] = '{
      SCLK_PER_NS[0] / (2 * CLK_NS), SCLK_PER_NS[1] / (2 * CLK_NS),
      SCLK_PER_NS[2] / (2 * CLK_NS), SCLK_PER_NS[3] / (2 * CLK_NS)};
   localparam int TRAIL_NS [4] = '{3, 60, 140, 300};
   localparam int TRAIL_CYC [4] = '{
      (TRAIL_NS[0] + CLK_NS - 1) / CLK_NS,
      (TRAIL_NS[1] + CLK_NS - 1) / CLK_NS,
      (TRAIL_NS[2] + CLK_NS - 1) / CLK_NS,
      (TRAIL_NS[3] + CLK_NS - 1) / CLK_NS};
   // synchronised pin vector layout and reset value
   localparam int PIN_W = 9;
   localparam int P_CNV_N = 8;
   localparam int P_SER = 7;
   localparam int P_EXT = 6;
   localparam int P_RDC = 5;
   localparam int P_DIV_HI = 4;
   localparam int P_DIV_LO = 3;
   localparam int P_CS_N = 2;
   localparam int P_RD_N = 1;
   localparam int P_SCLK = 0;
   localparam logic [PIN_W-1:0] PIN_RST = 9'h106;
   // states
   typedef enum logic [2:0] {C_IDLE, C_CONV, C_TAIL, C_WAIT, C_LAG} sac_conv_t;
   typedef enum logic [1:0] {F_IDLE, F_LEAD, F_SHIFT, F_TRAIL} sac_frame_t;
endpackage

// ---- design/sac_top.sv ----
// conversion handshake, busy timing and parallel or serial result readout
// Operation
// - busy rises within 30 ns of start
// - busy at most 1.25 us otherwise
// - busy falls 10 ns after conversion end
// - parallel data valid 45 ns before busy falls
// - bus drive within 40 ns, release 15 ns
// - master outputs driven 10 ns after select
// - master outputs released 10 ns after deselect
// - serial clock period minimum per divider code
// - serial clock period maximum per divider code
// - master read-after-convert busy bounded per code
// - first clock edge delayed after frame marker
// - frame marker held after last clock edge
// - frame marker asserted once conversion completes
// - busy falls 25 ns after frame ends
// - slave data updates 3 to 18 ns
`timescale 1ns/100ps
`default_nettype none
module sac_top (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // conversion control pins
   input wire logic i_conversion_start_n,
   output logic o_busy,
   // result from the internal converter core
   input wire logic [sac_pkg::DATA_W-1:0] i_core_result,
   // mode select pins
   input wire logic i_interface_select,
   input wire logic i_clock_source_select,
   input wire logic i_serial_data_in,
   input wire logic [1:0] i_clock_divide_select,
   // bus access pins
   input wire logic i_cs_n,
   input wire logic i_rd_n,
   // parallel port
   output logic [sac_pkg::DATA_W-1:0] o_data,
   output logic o_data_oe,
   // serial port
   output logic o_serial_data_out,
   output logic o_serial_data_out_oe,
   output logic o_frame_marker,
   output logic o_frame_marker_oe,
   output logic o_sclk_out,
   output logic o_sclk_oe,
   input wire logic i_sclk_in
);
   import sac_pkg::*;

   logic [1:0] rst_sync_ff;
   logic rst_n;
   logic [PIN_W-1:0] pin_meta_ff;
   logic [PIN_W-1:0] pin_ff;
   logic cnv_prev_ff;
   logic sclk_prev_ff;
   sac_conv_t conv_st_ff;
   logic [CNT_W-1:0] conv_cnt_ff;
   logic busy_ff;
   logic [DATA_W-1:0] buf_mem_ff [2];
   logic wr_ptr_ff;
   logic rd_ptr_ff;
   logic [1:0] buf_cnt_ff;
   logic [DATA_W-1:0] pdata_ff;
   sac_frame_t frm_st_ff;
   logic [CNT_W-1:0] frm_cnt_ff;
   logic [4:0] bit_cnt_ff;
   logic [DATA_W-1:0] shift_ff;
   logic sclk_ff;
   logic sync_ff;
   logic frame_done_ff;
   logic slave_full_ff;

   // reset release through two flops
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'h1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   // every pin is asynchronous to i_clk, so all pass two flops
   // a start pulse shorter than one clock may go unseen
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_ff <= PIN_RST;
         pin_ff <= PIN_RST;
         cnv_prev_ff <= 1'h1;
         sclk_prev_ff <= 1'h0;
      end else begin
         pin_meta_ff <= {i_conversion_start_n, i_interface_select,
            i_clock_source_select, i_serial_data_in, i_clock_divide_select,
            i_cs_n, i_rd_n, i_sclk_in};
         pin_ff <= pin_meta_ff;
         cnv_prev_ff <= pin_ff[P_CNV_N];
         sclk_prev_ff <= pin_ff[P_SCLK];
      end
   end

   // decoded modes
   wire ser_mode = pin_ff[P_SER];
   wire ext_clk = pin_ff[P_EXT];
   wire cs_act = !pin_ff[P_CS_N];
   wire rd_act = !pin_ff[P_RD_N];
   wire [1:0] div_code = {pin_ff[P_DIV_HI], pin_ff[P_DIV_LO]};
   wire master_mode = ser_mode && !ext_clk;
   wire slave_mode = ser_mode && ext_clk;
   wire rac_mode = master_mode && !pin_ff[P_RDC];
   wire start_fall = cnv_prev_ff && !pin_ff[P_CNV_N];
   wire sclk_rise = pin_ff[P_SCLK] && !sclk_prev_ff;
   wire [CNT_W-1:0] half_cyc = CNT_W'(HALF_CYC[div_code]);
   wire [CNT_W-1:0] trail_cyc = CNT_W'(TRAIL_CYC[div_code]);

   // two-entry result buffer handshake
   wire buf_in_valid = (conv_st_ff == C_CONV) && (conv_cnt_ff == 8'h00);
   wire buf_in_ready = (buf_cnt_ff != 2'h2);
   wire buf_out_valid = (buf_cnt_ff != 2'h0);
   wire frame_free = (frm_st_ff == F_IDLE);
   // serial receivers stall the buffer until the last word has gone out
   wire buf_out_ready = !ser_mode ||
      (master_mode && frame_free) || (slave_mode && !slave_full_ff);
   wire buf_push = buf_in_valid && buf_in_ready;
   wire buf_pop = buf_out_valid && buf_out_ready;
   wire [DATA_W-1:0] buf_out_data = buf_mem_ff[rd_ptr_ff];

   // conversion sequencer; a start while busy is ignored
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         conv_st_ff <= C_IDLE;
         conv_cnt_ff <= 8'h00;
         busy_ff <= 1'h0;
      end else begin
         unique case (conv_st_ff)
            C_IDLE: begin
               if (start_fall) begin
                  busy_ff <= 1'h1;
                  conv_cnt_ff <= CNT_W'(CONV_CYC);
                  conv_st_ff <= C_CONV;
               end
            end
            C_CONV: begin
               if (conv_cnt_ff != 8'h00) begin
                  conv_cnt_ff <= conv_cnt_ff - 8'h01;
               end else if (buf_in_ready) begin
                  // a full buffer holds the result back, busy stays up
                  conv_cnt_ff <= CNT_W'(TAIL_CYC);
                  conv_st_ff <= C_TAIL;
               end
            end
            C_TAIL: begin
               if (conv_cnt_ff != 8'h00) begin
                  conv_cnt_ff <= conv_cnt_ff - 8'h01;
               end else if (rac_mode) begin
                  conv_st_ff <= C_WAIT;
               end else begin
                  busy_ff <= 1'h0;
                  conv_st_ff <= C_IDLE;
               end
            end
            C_WAIT: begin
               // read-after-convert holds busy until the frame is out
               if (frame_done_ff) begin
                  conv_cnt_ff <= CNT_W'(LAG_CYC - 1);
                  conv_st_ff <= C_LAG;
               end
            end
            C_LAG: begin
               if (conv_cnt_ff != 8'h00) begin
                  conv_cnt_ff <= conv_cnt_ff - 8'h01;
               end else begin
                  busy_ff <= 1'h0;
                  conv_st_ff <= C_IDLE;
               end
            end
         endcase
      end
   end

   // buffer storage and pointers
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         buf_mem_ff[0] <= 16'h0000;
         buf_mem_ff[1] <= 16'h0000;
         wr_ptr_ff <= 1'h0;
         rd_ptr_ff <= 1'h0;
         buf_cnt_ff <= 2'h0;
      end else begin
         if (buf_push) begin
            buf_mem_ff[wr_ptr_ff] <= i_core_result;
            wr_ptr_ff <= !wr_ptr_ff;
         end
         if (buf_pop) begin
            rd_ptr_ff <= !rd_ptr_ff;
         end
         // push and pop in one cycle leave the count alone
         buf_cnt_ff <= buf_cnt_ff + {1'h0, buf_push} - {1'h0, buf_pop};
      end
   end

   // parallel result register, loaded ahead of busy falling
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         pdata_ff <= 16'h0000;
      end else if (buf_pop && !ser_mode) begin
         pdata_ff <= buf_out_data;
      end
   end

   // serial master frame and slave shifter
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         frm_st_ff <= F_IDLE;
         frm_cnt_ff <= 8'h00;
         bit_cnt_ff <= 5'h00;
         shift_ff <= 16'h0000;
         sclk_ff <= 1'h0;
         sync_ff <= 1'h0;
         frame_done_ff <= 1'h0;
         slave_full_ff <= 1'h0;
      end else begin
         frame_done_ff <= 1'h0;
         unique case (frm_st_ff)
            F_IDLE: begin
               if (buf_pop && master_mode) begin
                  shift_ff <= buf_out_data;
                  sync_ff <= 1'h1;
                  frm_cnt_ff <= CNT_W'(LEAD_CYC - 1);
                  bit_cnt_ff <= 5'h00;
                  frm_st_ff <= F_LEAD;
               end else if (buf_pop && slave_mode) begin
                  shift_ff <= buf_out_data;
                  bit_cnt_ff <= 5'h00;
                  slave_full_ff <= 1'h1;
               end else if (slave_full_ff && sclk_rise) begin
                  // msb first, next bit on each rising host clock edge
                  shift_ff <= {shift_ff[DATA_W-2:0], 1'h0};
                  bit_cnt_ff <= bit_cnt_ff + 5'h01;
                  if (bit_cnt_ff == 5'(DATA_W - 1)) begin
                     slave_full_ff <= 1'h0;
                  end
               end
            end
            F_LEAD: begin
               if (frm_cnt_ff != 8'h00) begin
                  frm_cnt_ff <= frm_cnt_ff - 8'h01;
               end else begin
                  frm_cnt_ff <= half_cyc - 8'h01;
                  frm_st_ff <= F_SHIFT;
               end
            end
            F_SHIFT: begin
               // fixed half period sits inside the allowed window
               if (frm_cnt_ff != 8'h00) begin
                  frm_cnt_ff <= frm_cnt_ff - 8'h01;
               end else if (!sclk_ff) begin
                  sclk_ff <= 1'h1;
                  frm_cnt_ff <= half_cyc - 8'h01;
               end else begin
                  sclk_ff <= 1'h0;
                  shift_ff <= {shift_ff[DATA_W-2:0], 1'h0};
                  bit_cnt_ff <= bit_cnt_ff + 5'h01;
                  if (bit_cnt_ff == 5'(DATA_W - 1)) begin
                     frm_cnt_ff <= trail_cyc - 8'h01;
                     frm_st_ff <= F_TRAIL;
                  end else begin
                     frm_cnt_ff <= half_cyc - 8'h01;
                  end
               end
            end
            F_TRAIL: begin
               if (frm_cnt_ff != 8'h00) begin
                  frm_cnt_ff <= frm_cnt_ff - 8'h01;
               end else begin
                  sync_ff <= 1'h0;
                  frame_done_ff <= 1'h1;
                  frm_st_ff <= F_IDLE;
               end
            end
         endcase
      end
   end

   // outputs; enables follow the synchronised select directly
   // no oe flop, so release stays two clocks after the pin
   assign o_busy = busy_ff;
   assign o_data = pdata_ff;
   assign o_data_oe = !ser_mode && cs_act && rd_act;
   assign o_serial_data_out = shift_ff[DATA_W-1];
   assign o_serial_data_out_oe = ser_mode && cs_act;
   assign o_frame_marker = sync_ff;
   assign o_frame_marker_oe = master_mode && cs_act;
   assign o_sclk_out = sclk_ff;
   assign o_sclk_oe = master_mode && cs_act;
endmodule
`default_nettype wire

// ---- bench/sac_chk_sva.sv ----
// checker of busy, bus and serial frame timing at the top ports
`timescale 1ns/100ps
`default_nettype none
module sac_chk (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // mode and request pins
   input wire logic i_conversion_start_n,
   input wire logic i_interface_select,
   input wire logic i_clock_source_select,
   input wire logic i_serial_data_in,
   input wire logic [1:0] i_clock_divide_select,
   input wire logic i_cs_n,
   input wire logic i_rd_n,
   // watched outputs
   input wire logic o_busy,
   input wire logic [sac_pkg::DATA_W-1:0] o_data,
   input wire logic o_data_oe,
   input wire logic o_frame_marker,
   input wire logic o_frame_marker_oe,
   input wire logic o_sclk_out,
   input wire logic o_sclk_oe,
   input wire logic o_serial_data_out_oe
);
   localparam int RAC_LIM [4] = '{400, 500, 700, 1150};
   localparam int PMIN [4] = '{5, 10, 20, 40};
   localparam int PMAX [4] = '{8, 14, 28, 56};
   localparam int TMIN [4] = '{1, 12, 28, 60};
   logic [10:0] bcnt_ff;
   logic [7:0] pcnt_ff, fcnt_ff;
   logic sclk_q_ff, seen_ff;
   wire rac = i_interface_select & ~i_clock_source_select & ~i_serial_data_in;
   wire mst = i_interface_select & ~i_clock_source_select;
   wire rise = o_sclk_out & ~sclk_q_ff;
   wire fall = ~o_sclk_out & sclk_q_ff;
   wire [1:0] dv = i_clock_divide_select;
   wire any_oe = o_sclk_oe | o_frame_marker_oe | o_serial_data_out_oe;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   // first rise of a frame has no period to judge
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         bcnt_ff <= 11'h000;
         pcnt_ff <= 8'h00;
         fcnt_ff <= 8'h00;
         sclk_q_ff <= 1'h0;
         seen_ff <= 1'h0;
      end else begin
         bcnt_ff <= o_busy ? bcnt_ff + 11'h001 : 11'h000;
         pcnt_ff <= rise ? 8'h01 : pcnt_ff + 8'h01;
         fcnt_ff <= fall ? 8'h01 : fcnt_ff + 8'h01;
         sclk_q_ff <= o_sclk_out;
         seen_ff <= o_frame_marker & (seen_ff | rise);
      end
   end
   AST_BUSY_RISE: assert property (
      $fell(i_conversion_start_n) && !o_busy |-> ##[1:6] o_busy)
      else $error("busy late after start");
   AST_BUSY_MAX: assert property (
      bcnt_ff <= (rac ? RAC_LIM[dv] : 250))
      else $error("busy held too long");
   AST_DATA_HOLD: assert property (
      $fell(o_busy) && !i_interface_select |-> o_data == $past(o_data, 9))
      else $error("data not settled before busy fell");
   AST_PAR_DRV: assert property (
      $rose(!i_cs_n && !i_rd_n && !i_interface_select) |-> ##[1:8] o_data_oe)
      else $error("bus not driven in time");
   AST_PAR_REL: assert property (
      $fell(!i_cs_n && !i_rd_n) |-> ##[1:3] !o_data_oe)
      else $error("bus not released in time");
   AST_MS_DRV: assert property (
      $fell(i_cs_n) && mst |-> ##[1:2] (o_sclk_oe && o_frame_marker_oe
      && o_serial_data_out_oe))
      else $error("serial outputs not driven after select");
   AST_MS_REL: assert property (
      $rose(i_cs_n) && i_interface_select |-> ##[1:2] !any_oe)
      else $error("serial outputs not released");
   AST_PERIOD: assert property (
      rise && seen_ff && mst |-> pcnt_ff >= PMIN[dv] && pcnt_ff <= PMAX[dv])
      else $error("serial clock period out of range");
   AST_LEAD: assert property (
      $rose(o_frame_marker) && mst && dv != 2'h0 |-> (!o_sclk_out) [*4])
      else $error("first clock edge too early");
   AST_LAG: assert property (
      $fell(o_frame_marker) && rac |-> ##[1:8] !o_busy)
      else $error("busy late after frame end");
   AST_FRAME_START: assert property (
      $fell(i_conversion_start_n) && !o_busy && rac |-> ##[230:250]
      o_frame_marker)
      else $error("frame marker not raised after conversion");
   AST_TRAIL: assert property (
      $fell(o_frame_marker) && mst |-> fcnt_ff >= TMIN[dv])
      else $error("frame marker dropped too soon");
   COV_PAR: cover property ($fell(o_busy) && !i_interface_select);
   COV_FRAME: cover property ($fell(o_frame_marker) && rac);
   COV_SLOW: cover property (rise && seen_ff && dv == 2'h3);
   COV_RDC: cover property ($fell(o_busy) && o_frame_marker);
endmodule
bind sac_top sac_chk sac_chk_i (.i_clk(i_clk), .i_arst_n(i_arst_n),
   .i_conversion_start_n(i_conversion_start_n), .o_busy(o_busy),
   .i_interface_select(i_interface_select), .i_cs_n(i_cs_n),
   .i_clock_source_select(i_clock_source_select), .i_rd_n(i_rd_n),
   .i_serial_data_in(i_serial_data_in), .o_data_oe(o_data_oe),
   .i_clock_divide_select(i_clock_divide_select), .o_data(o_data),
   .o_frame_marker(o_frame_marker), .o_frame_marker_oe(o_frame_marker_oe),
   .o_sclk_out(o_sclk_out), .o_sclk_oe(o_sclk_oe),
   .o_serial_data_out_oe(o_serial_data_out_oe));
`default_nettype wire

// ---- bench/sac_host_model.sv ----
// host model: slave clock source and msb-first word capture
`timescale 1ns/100ps
`default_nettype none
module sac_host_model (
   // clock and serial pins
   input wire logic i_clk,
   input wire logic i_sclk,
   input wire logic i_sdo,
   input wire logic i_sdo_oe,
   // bench control
   input wire logic i_clear,
   input wire logic i_go,
   input wire logic [3:0] i_half,
   // results
   output logic o_sclk_in,
   output logic [15:0] o_word,
   output logic [4:0] o_bits
);
   wire sck = i_sclk | o_sclk_in;
   initial o_sclk_in = 1'b0;
   // clock stands still between frames; half sets prompt or slow
   always @(posedge i_go) begin
      repeat (16) begin
         repeat (i_half) @(negedge i_clk);
         o_sclk_in = 1'b1;
         repeat (i_half) @(negedge i_clk);
         o_sclk_in = 1'b0;
      end
   end
   // sixteen bits a frame, msb first, only while driven
   always @(posedge sck or posedge i_clear) begin
      if (i_clear) begin
         o_word <= '0;
         o_bits <= '0;
      end else if (i_sdo_oe && o_bits < 5'h10) begin
         o_word <= {o_word[14:0], i_sdo};
         o_bits <= o_bits + 5'h01;
      end
   end
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// testbench: parallel, serial master and serial slave readout
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic clk = 1'b0, arst_n = 1'b0, cnv_n = 1'b1, ser = 1'b0, ext = 1'b0;
   logic cs_n = 1'b1, rd_n = 1'b1, clr = 1'b0, go = 1'b0, rdc = 1'b0;
   logic [1:0] dv = 2'h0;
   logic [3:0] half = 4'h3;
   logic [15:0] res = 16'h0000, data, word;
   logic busy, doe, sdo, sdo_oe, fm, fm_oe, sclk, sclk_oe, sclk_in;
   logic [4:0] bits;
   int err_count = 0, checked = 0;
   always #2.5 clk = ~clk;
   sac_top sac_top_i (.i_clk(clk), .i_arst_n(arst_n),
      .i_conversion_start_n(cnv_n), .o_busy(busy), .i_core_result(res),
      .i_interface_select(ser), .i_clock_source_select(ext),
      .i_serial_data_in(rdc), .i_clock_divide_select(dv), .i_cs_n(cs_n),
      .i_rd_n(rd_n), .o_data(data), .o_data_oe(doe),
      .o_serial_data_out(sdo), .o_serial_data_out_oe(sdo_oe),
      .o_frame_marker(fm), .o_frame_marker_oe(fm_oe), .o_sclk_out(sclk),
      .o_sclk_oe(sclk_oe), .i_sclk_in(sclk_in));
   sac_host_model sac_host_model_i (.i_clk(clk), .i_sclk(sclk),
      .i_sdo(sdo), .i_sdo_oe(sdo_oe), .i_clear(clr), .i_go(go),
      .i_half(half), .o_sclk_in(sclk_in), .o_word(word), .o_bits(bits));
   task automatic end_sim;
      $display("checked %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_le(input int got, input int lim);
      checked++;
      if (got > lim) begin
         err_count++;
         $display("Error at %0t: got %h limit %h", $time, got, lim);
      end
   endtask
   // one start pulse; host waits for busy to fall before the next
   task automatic conv(input int lim);
      int n;
      n = 0;
      cnv_n = 1'b0;
      while (busy !== 1'b1 && n < 50) begin
         @(negedge clk);
         n++;
      end
      chk_le(n, 6);
      cnv_n = 1'b1;
      n = 0;
      while (busy !== 1'b0 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      chk_le(n, lim);
   endtask
   task automatic t_par;
      ser = 1'b0;
      res = 16'hA5C3;
      conv(250);
      cs_n = 1'b0;
      rd_n = 1'b0;
      repeat (8) @(negedge clk);
      chk_val(16'(doe), 16'h0001);
      chk_val(data, 16'hA5C3);
      cs_n = 1'b1;
      rd_n = 1'b1;
      repeat (3) @(negedge clk);
      chk_val(16'(doe), 16'h0000);
      $display("parallel readout done");
   endtask
   task automatic t_ms(input logic [1:0] c, input logic [15:0] v, int lim);
      ser = 1'b1;
      ext = 1'b0;
      dv = c;
      res = v;
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      cs_n = 1'b0;
      repeat (4) @(negedge clk);
      conv(lim);
      chk_val(word, v);
      chk_val(16'(bits), 16'h0010);
      cs_n = 1'b1;
      repeat (4) @(negedge clk);
      $display("serial master code %0d done", c);
   endtask
   // read during convert: busy falls at conversion end, frame runs on
   task automatic t_mrd(input logic [15:0] v);
      ser = 1'b1;
      ext = 1'b0;
      rdc = 1'b1;
      dv = 2'h0;
      res = v;
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      cs_n = 1'b0;
      repeat (4) @(negedge clk);
      conv(250);
      repeat (120) @(negedge clk);
      chk_val(word, v);
      chk_val(16'(bits), 16'h0010);
      cs_n = 1'b1;
      repeat (4) @(negedge clk);
      rdc = 1'b0;
      $display("serial master read during done");
   endtask
   task automatic t_sl(input logic [15:0] v, input logic [3:0] h);
      ser = 1'b1;
      ext = 1'b1;
      res = v;
      half = h;
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      cs_n = 1'b0;
      repeat (4) @(negedge clk);
      conv(250);
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
      repeat (32 * h + 8) @(negedge clk);
      chk_val(word, v);
      cs_n = 1'b1;
      repeat (4) @(negedge clk);
      $display("serial slave half %0d done", h);
   endtask
   initial begin
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
      repeat (6) @(negedge clk);
      t_par;
      t_ms(2'h0, 16'h8001, 400);
      t_ms(2'h1, 16'h3C5A, 500);
      t_ms(2'h2, 16'hF00F, 700);
      t_ms(2'h3, 16'h1234, 1150);
      t_mrd(16'h6E91);
      t_sl(16'hC3A5, 4'h3);
      t_sl(16'h5AA5, 4'h8);
      end_sim;
   end
   // run needs about 21 us; hang cut well beyond that
   initial begin
      #100000;
      err_count++;
      end_sim;
   end
endmodule
`default_nettype wire
